//--- common/itfs_cfg.svh
`ifndef ITFS_CFG_SVH
`define ITFS_CFG_SVH

// Register offsets of the eight selection settings
`define ITFS_OFS_ONE     16'h0438
`define ITFS_OFS_TWO     16'h0439
`define ITFS_OFS_THREE   16'h0400
`define ITFS_OFS_FOUR    16'h0401
`define ITFS_OFS_FIVE    16'h0402
`define ITFS_OFS_SIX     16'h0403
`define ITFS_OFS_SEVEN   16'h0404
`define ITFS_OFS_EIGHT   16'h0405

// Normal defaults
`define ITFS_RST_ONE     16'h0040
`define ITFS_RST_TWO     16'h0041
`define ITFS_RST_THREE   16'h0024
`define ITFS_RST_FOUR    16'h0014
`define ITFS_RST_FIVE    16'h0003
`define ITFS_RST_SIX     16'h0004
`define ITFS_RST_SEVEN   16'h0006
`define ITFS_RST_EIGHT   16'h0008

// Defaults after a three-wire initialization
`define ITFS_ALT_FIVE    16'h0000
`define ITFS_ALT_SIX     16'h0003
`define ITFS_ALT_SEVEN   16'h0004
`define ITFS_ALT_EIGHT   16'h0006

// Legal code range
`define ITFS_CODE_MAX    16'h009f
`define ITFS_MIN_FIRST   16'h0001
`define ITFS_MIN_OTHER   16'h0000

// Function codes
`define ITFS_F_THREE_WIRE 16'h0000
`define ITFS_F_LOCAL      16'h0001
`define ITFS_F_SRC_TWO    16'h0002
`define ITFS_F_STEP_B0    16'h0003
`define ITFS_F_STEP_B1    16'h0004
`define ITFS_F_STEP_B2    16'h0005
`define ITFS_F_JOG        16'h0006
`define ITFS_F_RAMP       16'h0007
`define ITFS_F_INH_NO     16'h0008
`define ITFS_F_INH_NC     16'h0009
`define ITFS_F_THROUGH    16'h000f

// Reference index of the jog reference, above the eight stored steps
`define ITFS_REF_JOG      4'h8
`define ITFS_NO_SLOT      4'hf

`endif

//--- common/itfs_pkg.sv
`default_nettype none
package itfs_pkg;
	typedef logic [15:0] itfs_code_type;
	typedef logic [7:0]  itfs_term_type;
	typedef logic [3:0]  itfs_ref_type;
endpackage
`default_nettype wire

//--- rtl/itfs_top.sv
// Function
// [R01] Eight terminal selection settings, codes up to 9F
// [R02] First two terminals minimum code 1, others 0
// [R03] Software should set unused terminals to F
// [R04] Three-wire init loads alternative default codes
// [R05] Code 0: reverse; terminals 1,2 run/stop
// [R06] Code 1: closed local, open remote
// [R07] Code 2: open source 1, closed source 2
// [R08] Codes 3,4,5 pick one of eight references
// [R09] Code 6: jog reference, overrides all others
// [R10] Code 7 selects ramp time set 1 or 2
// [R11] Code 8: closed terminal blocks drive output
// [R12] Code 9: open terminal blocks drive output
// [R13] Code F: no function, state readable
// [R14] Binary step weight, code 3 is LSB
// [R15] Unassigned step bit reads as open
`include "itfs_cfg.svh"
`default_nettype none
module itfs_top
(
	input  wire logic                    CLOCK,
	input  wire logic                    RST_N,
	input  wire itfs_pkg::itfs_term_type TERM_IN,
	input  wire itfs_pkg::itfs_code_type REG_ADDR,
	input  wire itfs_pkg::itfs_code_type REG_WDATA,
	input  wire logic                    REG_WR,
	input  wire logic                    REG_RD,
	input  wire logic                    INIT_TWO_WIRE,
	input  wire logic                    INIT_THREE_WIRE,
	output var  itfs_pkg::itfs_code_type REG_RDATA,
	output var  logic                    REG_ERR,
	output var  logic                    THREE_WIRE_EN,
	output var  logic                    RUN_CMD,
	output var  logic                    STOP_CMD,
	output var  logic                    REVERSE_CMD,
	output var  logic                    LOCAL_SEL,
	output var  logic                    SOURCE_TWO_SEL,
	output var  itfs_pkg::itfs_ref_type  REF_INDEX,
	output var  logic                    JOG_SEL,
	output var  logic                    RAMP_SET_TWO,
	output var  logic                    OUTPUT_INHIBIT,
	output var  itfs_pkg::itfs_term_type THROUGH_STATE
);
	import itfs_pkg::*;

	itfs_code_type sel_q [8];
	itfs_term_type meta_q;
	itfs_term_type term_q;

	// Register offset to terminal slot; no slot for unmapped addresses
	function automatic itfs_ref_type slot_of(input itfs_code_type a);
		case (a)
			`ITFS_OFS_ONE:   slot_of = 4'h0;
			`ITFS_OFS_TWO:   slot_of = 4'h1;
			`ITFS_OFS_THREE: slot_of = 4'h2;
			`ITFS_OFS_FOUR:  slot_of = 4'h3;
			`ITFS_OFS_FIVE:  slot_of = 4'h4;
			`ITFS_OFS_SIX:   slot_of = 4'h5;
			`ITFS_OFS_SEVEN: slot_of = 4'h6;
			`ITFS_OFS_EIGHT: slot_of = 4'h7;
			default:         slot_of = `ITFS_NO_SLOT;
		endcase
	endfunction

	// Mask of terminals that hold a given function code
	function automatic itfs_term_type holders(input itfs_code_type c,
		input itfs_code_type s0, input itfs_code_type s1,
		input itfs_code_type s2, input itfs_code_type s3,
		input itfs_code_type s4, input itfs_code_type s5,
		input itfs_code_type s6, input itfs_code_type s7);
		holders = {s7 == c, s6 == c, s5 == c, s4 == c,
			s3 == c, s2 == c, s1 == c, s0 == c};
	endfunction

	// Write qualification
	// A refused write leaves the setting untouched and only pulses REG_ERR
	wire itfs_ref_type  wr_slot = slot_of(REG_ADDR);
	wire logic          wr_map  = (wr_slot != `ITFS_NO_SLOT);
	wire itfs_code_type wr_min  = (wr_slot < 4'h2) ? `ITFS_MIN_FIRST
		: `ITFS_MIN_OTHER; // [R02]
	wire logic wr_legal = wr_map && (REG_WDATA <= `ITFS_CODE_MAX)
		&& (REG_WDATA >= wr_min); // [R01] [R02]
	wire logic wr_ok  = REG_WR && wr_legal;
	wire logic wr_bad = REG_WR && !wr_legal;
	wire logic rd_map = (slot_of(REG_ADDR) != `ITFS_NO_SLOT);
	wire itfs_code_type rd_val = rd_map ? sel_q[wr_slot[2:0]] : 16'h0000;

	// Terminal function masks
	// Full 16-bit compare, so codes outside 0 to 9 and F select nothing
	wire itfs_term_type m_3w   = holders(`ITFS_F_THREE_WIRE, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);
	wire itfs_term_type m_loc  = holders(`ITFS_F_LOCAL, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);
	wire itfs_term_type m_src  = holders(`ITFS_F_SRC_TWO, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);
	wire itfs_term_type m_b0   = holders(`ITFS_F_STEP_B0, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);
	wire itfs_term_type m_b1   = holders(`ITFS_F_STEP_B1, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);
	wire itfs_term_type m_b2   = holders(`ITFS_F_STEP_B2, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);
	wire itfs_term_type m_jog  = holders(`ITFS_F_JOG, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);
	wire itfs_term_type m_ramp = holders(`ITFS_F_RAMP, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);
	wire itfs_term_type m_no   = holders(`ITFS_F_INH_NO, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);
	wire itfs_term_type m_nc   = holders(`ITFS_F_INH_NC, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);
	wire itfs_term_type m_thr  = holders(`ITFS_F_THROUGH, sel_q[0],
		sel_q[1], sel_q[2], sel_q[3], sel_q[4], sel_q[5], sel_q[6], sel_q[7]);

	// In three-wire mode the first two terminals leave their own functions
	wire logic          tw_d  = |m_3w; // [R05]
	wire itfs_term_type own   = tw_d ? 8'hfc : 8'hff; // [R05]
	wire itfs_term_type act   = term_q & own;
	wire itfs_term_type opn   = ~term_q & own;

	// Step bits absent from every terminal stay open
	wire logic [2:0] step_d = {|(m_b2 & act), |(m_b1 & act),
		|(m_b0 & act)}; // [R08] [R14] [R15]
	wire logic jog_d = |(m_jog & act); // [R09]
	wire itfs_ref_type ref_d = jog_d ? `ITFS_REF_JOG
		: {1'b0, step_d}; // [R09] [R08]
	wire logic inh_d = |(m_no & act) | |(m_nc & opn); // [R11] [R12]

	// Defaults loaded by an initialization command; three-wire wins
	wire logic          init_any   = INIT_THREE_WIRE || INIT_TWO_WIRE;
	wire itfs_code_type init_five  = INIT_THREE_WIRE ? `ITFS_ALT_FIVE
		: `ITFS_RST_FIVE; // [R04]
	wire itfs_code_type init_six   = INIT_THREE_WIRE ? `ITFS_ALT_SIX
		: `ITFS_RST_SIX; // [R04]
	wire itfs_code_type init_seven = INIT_THREE_WIRE ? `ITFS_ALT_SEVEN
		: `ITFS_RST_SEVEN; // [R04]
	wire itfs_code_type init_eight = INIT_THREE_WIRE ? `ITFS_ALT_EIGHT
		: `ITFS_RST_EIGHT; // [R04]

	// Terminal pins are asynchronous to CLOCK; first synchroniser stage
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			meta_q <= 8'h00;
		else
			meta_q <= TERM_IN;
	end

	// Second stage; only this one feeds the decode, never meta_q
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			term_q <= 8'h00;
		else
			term_q <= meta_q;
	end

	// Selection settings; initialization wins over a same-cycle write
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sel_q[0] <= `ITFS_RST_ONE;
			sel_q[1] <= `ITFS_RST_TWO;
			sel_q[2] <= `ITFS_RST_THREE;
			sel_q[3] <= `ITFS_RST_FOUR;
			sel_q[4] <= `ITFS_RST_FIVE;
			sel_q[5] <= `ITFS_RST_SIX;
			sel_q[6] <= `ITFS_RST_SEVEN;
			sel_q[7] <= `ITFS_RST_EIGHT;
		end
		else if (init_any)
		begin
			sel_q[0] <= `ITFS_RST_ONE;
			sel_q[1] <= `ITFS_RST_TWO;
			sel_q[2] <= `ITFS_RST_THREE;
			sel_q[3] <= `ITFS_RST_FOUR;
			sel_q[4] <= init_five; // [R04]
			sel_q[5] <= init_six; // [R04]
			sel_q[6] <= init_seven; // [R04]
			sel_q[7] <= init_eight; // [R04]
		end
		else if (wr_ok)
			sel_q[wr_slot[2:0]] <= REG_WDATA; // [R01]
	end

	// Read data holds between reads, so the host may fetch it late
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			REG_RDATA <= 16'h0000;
		else if (REG_RD)
			REG_RDATA <= rd_val; // [R01]
	end

	// One-cycle error pulse for a refused write or an unmapped read
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			REG_ERR <= 1'b0;
		else
			REG_ERR <= wr_bad || (REG_RD && !rd_map); // [R01] [R02]
	end

	// Three-wire mode follows the settings, not the terminals
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			THREE_WIRE_EN <= 1'b0;
		else
			THREE_WIRE_EN <= tw_d; // [R05]
	end

	// Run contact on terminal one
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			RUN_CMD <= 1'b0;
		else
			RUN_CMD <= tw_d && term_q[0]; // [R05]
	end

	// Stop is a break contact, so a broken wire also stops the drive
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			STOP_CMD <= 1'b0;
		else
			STOP_CMD <= tw_d && !term_q[1]; // [R05]
	end

	// Reverse from any closed code-0 terminal
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			REVERSE_CMD <= 1'b0;
		else
			REVERSE_CMD <= tw_d && |(m_3w & act); // [R05]
	end

	// Local when closed, remote when open
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			LOCAL_SEL <= 1'b0;
		else
			LOCAL_SEL <= |(m_loc & act); // [R06]
	end

	// Source set two when closed
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			SOURCE_TWO_SEL <= 1'b0;
		else
			SOURCE_TWO_SEL <= |(m_src & act); // [R07]
	end

	// Reference index; jog sits above the stored steps
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			REF_INDEX <= 4'h0;
		else
			REF_INDEX <= ref_d; // [R08] [R09]
	end

	// Jog flag, registered with the index so both move together
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			JOG_SEL <= 1'b0;
		else
			JOG_SEL <= jog_d; // [R09]
	end

	// Ramp time set two when closed
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			RAMP_SET_TWO <= 1'b0;
		else
			RAMP_SET_TWO <= |(m_ramp & act); // [R10]
	end

	// Output inhibit for either contact sense
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			OUTPUT_INHIBIT <= 1'b0;
		else
			OUTPUT_INHIBIT <= inh_d; // [R11] [R12]
	end

	// Pass-through terminals; all other bits read as open
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			THROUGH_STATE <= 8'h00;
		else
			THROUGH_STATE <= m_thr & term_q; // [R13]
	end
endmodule
`default_nettype wire

//--- tb/itfs_props.sv
`default_nettype none
module itfs_props
	import itfs_pkg::*;
(
	input wire logic          CLOCK,
	input wire logic          RST_N,
	input wire itfs_term_type TERM_IN,
	input wire itfs_code_type REG_ADDR,
	input wire itfs_code_type REG_WDATA,
	input wire logic          REG_WR,
	input wire logic          REG_RD,
	input wire itfs_code_type REG_RDATA,
	input wire logic          REG_ERR,
	input wire logic          THREE_WIRE_EN,
	input wire logic          RUN_CMD,
	input wire logic          JOG_SEL,
	input wire itfs_ref_type  REF_INDEX,
	input wire itfs_term_type THROUGH_STATE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);
	// Writes that must be turned away
	sequence big_wr;
		REG_WR && REG_WDATA > 16'h009f;
	endsequence
	sequence zero_wr;
		REG_WR && REG_ADDR[15:1] == 15'h021c && REG_WDATA == 16'h0000;
	endsequence
	code_max_a: assert property (big_wr |=> REG_ERR)
		else $error("oversized code accepted");
	code_min_a: assert property (zero_wr |=> REG_ERR)
		else $error("zero code accepted on first pair");
	err_cause_a: assert property (REG_ERR
		|-> $past(REG_WR) || $past(REG_RD))
		else $error("error flag without access");
	hole_read_a: assert property (REG_RD && REG_ADDR == 16'h0500
		|=> REG_ERR && REG_RDATA == 16'h0000)
		else $error("unmapped read not flagged");
	rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved");
	run_mode_a: assert property (RUN_CMD |-> THREE_WIRE_EN
		&& $past(TERM_IN[0], 3))
		else $error("run outside three-wire mode");
	jog_index_a: assert property (JOG_SEL |-> REF_INDEX == 4'h8
		&& $past(TERM_IN, 3) != 8'h00)
		else $error("jog not on top");
	step_range_a: assert property (!JOG_SEL |-> REF_INDEX < 4'h8)
		else $error("step index out of range");
	// Sync chain plus output register gives three edges
	through_mask_a: assert property
		((THROUGH_STATE & ~$past(TERM_IN, 3)) == 8'h00)
		else $error("pass-through shows open terminal");
endmodule
`default_nettype wire

//--- tb/itfs_contacts.sv
`default_nettype none
module itfs_contacts
(
	input  wire logic       CLOCK,
	input  wire logic [7:0] want,
	input  wire logic       slow,
	output wire logic [7:0] term
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] lag_q = 3'h0;
	logic [7:0] term_q = 8'h00;
	// All contacts open at start; one process owns the state
	assign term = term_q;
	// Slow contacts settle seven cycles late, like a sluggish relay
	always @(posedge CLOCK)
	begin
		lag_q <= (want == term_q) ? 3'h0 : lag_q + 3'h1;
		if (want != term_q && (!slow || lag_q == 3'h6))
			term_q <= want;
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import itfs_pkg::*;
	logic CLOCK = 1'b0;
	logic RST_N, REG_WR, REG_RD, INIT_TWO_WIRE, INIT_THREE_WIRE, slow;
	logic REG_ERR, THREE_WIRE_EN, RUN_CMD, STOP_CMD, REVERSE_CMD;
	logic LOCAL_SEL, SOURCE_TWO_SEL, JOG_SEL, RAMP_SET_TWO, OUTPUT_INHIBIT;
	itfs_code_type REG_ADDR, REG_WDATA, REG_RDATA;
	itfs_term_type want, TERM_IN, THROUGH_STATE;
	itfs_ref_type  REF_INDEX;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [2:0] b;
	itfs_code_type ofs[8] = '{16'h0438, 16'h0439, 16'h0400, 16'h0401,
		16'h0402, 16'h0403, 16'h0404, 16'h0405};
	itfs_code_type dfl[8] = '{16'h0040, 16'h0041, 16'h0024, 16'h0014,
		16'h0003, 16'h0004, 16'h0006, 16'h0008};
	itfs_code_type fc[4] = '{16'h0001, 16'h0002, 16'h0007, 16'h000f};
	wire [3:0] lvl = {LOCAL_SEL, SOURCE_TWO_SEL, RAMP_SET_TWO, THROUGH_STATE[3]};
	wire [3:0] wire3 = {THREE_WIRE_EN, RUN_CMD, STOP_CMD, REVERSE_CMD};
	always #25 CLOCK = ~CLOCK;
	itfs_top i_itfs_top (.*);
	itfs_contacts i_itfs_contacts (.CLOCK, .want, .slow, .term(TERM_IN));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// One register access; flags are settled one edge later
	task automatic acc(input logic wr, input itfs_code_type a, d);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= wr;
		REG_RD <= !wr;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
		#1;
	endtask
	// Room for a slow contact plus the three-edge input path
	task automatic pins(input itfs_term_type v);
		@(posedge CLOCK);
		want <= v;
		repeat (12) @(posedge CLOCK);
		#1;
	endtask
	task automatic pulse(input logic three);
		@(posedge CLOCK);
		INIT_THREE_WIRE <= three;
		INIT_TWO_WIRE <= !three;
		@(posedge CLOCK);
		INIT_THREE_WIRE <= 1'b0;
		INIT_TWO_WIRE <= 1'b0;
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles needed
	always @(posedge CLOCK)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			summarize;
		end
	end
	initial
	begin
		{RST_N, REG_WR, REG_RD, INIT_TWO_WIRE, INIT_THREE_WIRE, slow} = 6'h00;
		{REG_ADDR, REG_WDATA, want} = 40'h0;
		repeat (10) @(posedge CLOCK);
		RST_N <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			acc(1'b0, ofs[i], 16'h0000);
			chk(REG_RDATA, dfl[i]);
		end
		acc(1'b0, 16'h0500, 16'h0000);
		chk({REG_RDATA[14:0], REG_ERR}, 16'h0001);
		acc(1'b1, 16'h0400, 16'h00a0);
		chk(REG_ERR, 1'b1);
		acc(1'b1, 16'h0438, 16'h0000);
		chk(REG_ERR, 1'b1);
		acc(1'b0, 16'h0400, 16'h0000);
		chk(REG_RDATA, 16'h0024);
		acc(1'b1, 16'h0400, 16'h009f);
		chk(REG_ERR, 1'b0);
		// Step bits without a code-5 terminal, then with one
		for (int k = 0; k < 2; k++)
		begin
			if (k == 1)
				acc(1'b1, 16'h0400, 16'h0005);
			for (int v = 0; v < 8; v++)
			begin
				b = v[2:0];
				pins({2'b00, b[1:0], 1'b0, b[2], 2'b00});
				chk(REF_INDEX, k ? b : {1'b0, b[1:0]});
			end
		end
		slow <= 1'b1;
		pins(8'h70);
		chk({JOG_SEL, REF_INDEX}, 5'h18);
		pins(8'h80);
		chk(OUTPUT_INHIBIT, 1'b1);
		acc(1'b1, 16'h0405, 16'h0009);
		pins(8'h00);
		chk(OUTPUT_INHIBIT, 1'b1);
		pins(8'h80);
		chk(OUTPUT_INHIBIT, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			acc(1'b1, 16'h0401, fc[i]);
			pins(8'h08);
			chk(lvl, 4'h8 >> i);
			chk(THROUGH_STATE, (i == 3) ? 16'h0008 : 16'h0000);
			pins(8'h00);
			chk(lvl, 4'h0);
		end
		// Alternative set: five is 0, six..eight take the step above
		pulse(1'b1);
		for (int i = 4; i < 8; i++)
		begin
			acc(1'b0, ofs[i], 16'h0000);
			chk(REG_RDATA, (i == 4) ? 16'h0000 : dfl[i - 1]);
		end
		pins(8'h11);
		chk(wire3, 4'hf);
		pins(8'h02);
		chk(wire3, 4'h8);
		pulse(1'b0);
		acc(1'b0, 16'h0402, 16'h0000);
		chk(REG_RDATA, 16'h0003);
		summarize;
	end
endmodule
bind itfs_top itfs_props i_itfs_props (.*);
`default_nettype wire
